/* rtl/phes_pkg.sv */
`default_nettype none
package phes_pkg;
    // bus widths
    localparam int PHES_AW = 16; // byte address width
    localparam int PHES_DW = 32;
    // register byte addresses
    localparam logic [15:0] PHES_A_SRC = 16'he600; // phase_event_source_status
    localparam logic [15:0] PHES_A_NL = 16'he604; // phase_no_load_status
    localparam logic [15:0] PHES_A_IST = 16'he608; // interrupt_status_main
    localparam logic [15:0] PHES_A_IMK = 16'he60c; // interrupt_mask_main
    // event source field positions
    localparam int PHES_OC_LSB = 3;
    localparam int PHES_OV_LSB = 9;
    localparam int PHES_SAG_LSB = 12;
    // no-load field positions
    localparam int PHES_TNL_LSB = 0;
    localparam int PHES_FNL_LSB = 3;
    localparam int PHES_ANL_LSB = 6;
    // summary flag positions in status and mask
    localparam int PHES_F_TNL = 0;
    localparam int PHES_F_FNL = 1;
    localparam int PHES_F_ANL = 2;
    localparam int PHES_F_SAG = 16;
    localparam int PHES_F_OC = 17;
    localparam int PHES_F_OV = 18;
    // implemented flag bits, others read zero
    localparam logic [31:0] PHES_F_IMPL = 32'h0007_0007;
    // reset values
    localparam logic [2:0] PHES_RST_PH = 3'h0;
    localparam logic [31:0] PHES_RST_W = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] PHES_OKAY = 2'h0;
    localparam logic [1:0] PHES_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PHES_WR_IDLE = 2'b01,
        PHES_WR_RESP = 2'b10
    } phes_wr_state_type;

    typedef enum logic [1:0] {
        PHES_RD_IDLE = 2'b01,
        PHES_RD_RESP = 2'b10
    } phes_rd_state_type;

    // byte enables widened to a bit mask
    function automatic logic [31:0] phes_lanes(input logic [3:0] strb);
        phes_lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
endpackage
`default_nettype wire

/* rtl/phes_rif.sv */
`default_nettype none
// register access strobes between bus front end and register file
interface phes_rif;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [15:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

/* rtl/phes_axil.sv */
`default_nettype none
// axi4-lite slave front end, one write and one read in flight
module phes_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [phes_pkg::PHES_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [phes_pkg::PHES_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [phes_pkg::PHES_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [phes_pkg::PHES_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    phes_rif.bus rif
);
    import phes_pkg::*;

    phes_wr_state_type wr_state; // write response state
    phes_rd_state_type rd_state; // read response state
    logic [PHES_AW-1:0] aw_addr; // parked write address
    logic [31:0] w_data; // parked write data
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_go;

    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign ar_take = arvalid && arready;
    // both halves parked, ready low marks a parked half
    assign wr_go = (wr_state == PHES_WR_IDLE) && !awready && !wready;
    assign rif.wr_en = wr_go;
    assign rif.wr_addr = aw_addr;
    assign rif.wr_data = w_data;
    assign rif.wr_strb = w_strb;
    // reads sample the register file at the address handshake
    assign rif.rd_en = ar_take;
    assign rif.rd_addr = araddr;

    // write address channel, reopens after the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_addr <= '0;
        end else if (aw_take) begin
            awready <= 1'b0;
            aw_addr <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // write data channel, may arrive before or after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_data <= PHES_RST_W;
            w_strb <= 4'h0;
        end else if (w_take) begin
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= PHES_WR_IDLE;
            bvalid <= 1'b0;
            bresp <= PHES_OKAY;
        end else begin
            unique case (wr_state)
                PHES_WR_IDLE: if (wr_go) begin
                    wr_state <= PHES_WR_RESP;
                    bvalid <= 1'b1;
                    bresp <= rif.wr_ok ? PHES_OKAY : PHES_SLVERR;
                end
                PHES_WR_RESP: if (bready) begin
                    wr_state <= PHES_WR_IDLE;
                    bvalid <= 1'b0;
                end
            endcase
        end
    end

    // read channel, data held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= PHES_RD_IDLE;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= PHES_RST_W;
            rresp <= PHES_OKAY;
        end else begin
            unique case (rd_state)
                PHES_RD_IDLE: if (ar_take) begin
                    rd_state <= PHES_RD_RESP;
                    arready <= 1'b0;
                    rvalid <= 1'b1;
                    rdata <= rif.rd_data;
                    rresp <= rif.rd_ok ? PHES_OKAY : PHES_SLVERR;
                end
                PHES_RD_RESP: if (rready) begin
                    rd_state <= PHES_RD_IDLE;
                    arready <= 1'b1;
                    rvalid <= 1'b0;
                end
            endcase
        end
    end
endmodule // phes_axil
`default_nettype wire

/* rtl/phes_regs.sv */
// Operation
// - reserved groups of both registers read zero
// - event source bit 15 reads zero
// - overcurrent phase bits 3-5 with flag 17
// - overvoltage phase bits 9-11 with flag 18
// - sag phase bits 12-14 with flag 16
// - no-load bits 0-2 track total power
// - total no-load sets flag 0 together
// - no-load bits 3-5 track fundamental power
// - fundamental no-load sets flag 1 together
// - no-load bits 6-8 track apparent power
// - apparent no-load sets flag 2 together
// - overcurrent interrupt only with mask bit 17
// - total no-load interrupt when mask bit 0
`default_nettype none
module phes_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [phes_pkg::PHES_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [phes_pkg::PHES_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [phes_pkg::PHES_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [phes_pkg::PHES_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [2:0] oc_evt,
    input wire logic [2:0] ov_evt,
    input wire logic [2:0] sag_evt,
    input wire logic [2:0] tnl_in,
    input wire logic [2:0] fnl_in,
    input wire logic [2:0] anl_in,
    output logic irq
);
    import phes_pkg::*;

    phes_rif rif ();

    // bus front end
    phes_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rif(rif)
    );

    // per-phase source indicators, sticky
    logic [2:0] overcurrent_source_phase;
    logic [2:0] overvoltage_source_phase;
    logic [2:0] sag_source_phase;
    // per-phase no-load indicators, live
    logic [2:0] total_power_noload_phase;
    logic [2:0] fundamental_noload_phase;
    logic [2:0] apparent_noload_phase;
    // summary flags and their enables
    logic [31:0] interrupt_status_main;
    logic [31:0] interrupt_mask_main;

    logic [2:0] next_oc;
    logic [2:0] next_ov;
    logic [2:0] next_sag;
    logic [31:0] next_status;
    logic [31:0] next_mask;
    logic [31:0] set_vec; // flags raised this cycle
    logic [31:0] clr_vec; // flags cleared by software
    logic [31:0] lanes;
    logic [15:0] src_word;
    logic [15:0] nl_word;
    logic wr_src;
    logic wr_nl;
    logic wr_ist;
    logic wr_imk;
    logic rd_src;
    logic rd_nl;
    logic rd_ist;
    logic rd_imk;
    logic tnl_enter;
    logic fnl_enter;
    logic anl_enter;

    // address decode
    assign wr_src = rif.wr_addr == PHES_A_SRC;
    assign wr_nl = rif.wr_addr == PHES_A_NL;
    assign wr_ist = rif.wr_en && (rif.wr_addr == PHES_A_IST);
    assign wr_imk = rif.wr_en && (rif.wr_addr == PHES_A_IMK);
    assign rd_src = rif.rd_addr == PHES_A_SRC;
    assign rd_nl = rif.rd_addr == PHES_A_NL;
    assign rd_ist = rif.rd_addr == PHES_A_IST;
    assign rd_imk = rif.rd_addr == PHES_A_IMK;
    // writes to the read-only pair are accepted and dropped
    assign rif.wr_ok = wr_src || wr_nl || (rif.wr_addr == PHES_A_IST)
        || (rif.wr_addr == PHES_A_IMK);
    assign rif.rd_ok = rd_src || rd_nl || rd_ist || rd_imk;

    // read words, reserved positions tied low
    assign src_word = {1'b0, sag_source_phase, overvoltage_source_phase,
        3'h0, overcurrent_source_phase, 3'h0};
    assign nl_word = {7'h00, apparent_noload_phase, fundamental_noload_phase,
        total_power_noload_phase};
    // unmapped reads return zero with slverr
    assign rif.rd_data = rd_src ? {16'h0000, src_word} :
        rd_nl ? {16'h0000, nl_word} :
        rd_ist ? interrupt_status_main :
        rd_imk ? interrupt_mask_main : PHES_RST_W;

    // write-one-to-clear, byte enables respected
    assign lanes = phes_lanes(rif.wr_strb);
    assign clr_vec = (wr_ist ? (rif.wr_data & lanes) : PHES_RST_W) & PHES_F_IMPL;

    // no-load entry of any phase raises the summary
    assign tnl_enter = |(tnl_in & ~total_power_noload_phase);
    assign fnl_enter = |(fnl_in & ~fundamental_noload_phase);
    assign anl_enter = |(anl_in & ~apparent_noload_phase);

    // raised flags, combined with clears below so a set wins
    always_comb begin
        set_vec = PHES_RST_W;
        set_vec[PHES_F_TNL] = tnl_enter;
        set_vec[PHES_F_FNL] = fnl_enter;
        set_vec[PHES_F_ANL] = anl_enter;
        set_vec[PHES_F_SAG] = |sag_evt;
        set_vec[PHES_F_OC] = |oc_evt;
        set_vec[PHES_F_OV] = |ov_evt;
    end

    assign next_status = (interrupt_status_main & ~clr_vec) | set_vec;
    assign next_mask = wr_imk ?
        ((interrupt_mask_main & ~lanes) | (rif.wr_data & lanes)) & PHES_F_IMPL :
        interrupt_mask_main;

    // source bits live as long as their summary flag; a new event wins
    assign next_oc = (overcurrent_source_phase & ~{3{clr_vec[PHES_F_OC]}})
        | oc_evt;
    assign next_ov = (overvoltage_source_phase & ~{3{clr_vec[PHES_F_OV]}})
        | ov_evt;
    assign next_sag = (sag_source_phase & ~{3{clr_vec[PHES_F_SAG]}})
        | sag_evt;

    // source indicators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overcurrent_source_phase <= PHES_RST_PH;
            overvoltage_source_phase <= PHES_RST_PH;
            sag_source_phase <= PHES_RST_PH;
        end else begin
            overcurrent_source_phase <= next_oc;
            overvoltage_source_phase <= next_ov;
            sag_source_phase <= next_sag;
        end
    end

    // no-load indicators follow the detectors, same edge as summaries
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            total_power_noload_phase <= PHES_RST_PH;
            fundamental_noload_phase <= PHES_RST_PH;
            apparent_noload_phase <= PHES_RST_PH;
        end else begin
            total_power_noload_phase <= tnl_in;
            fundamental_noload_phase <= fnl_in;
            apparent_noload_phase <= anl_in;
        end
    end

    // status, mask and interrupt line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_status_main <= PHES_RST_W;
            interrupt_mask_main <= PHES_RST_W;
            irq <= 1'b0;
        end else begin
            interrupt_status_main <= next_status;
            interrupt_mask_main <= next_mask;
            // built from next values so irq tracks status with no lag
            irq <= |(next_status & next_mask);
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_resv_zero: assert property (
        src_word[2:0] == 3'h0 && src_word[8:6] == 3'h0 && nl_word[15:9] == 7'h00)
        else $error("reserved bits not zero");

    chk_src_top: assert property (
        rd_src |-> rif.rd_data[15] == 1'b0)
        else $error("event source bit 15 set");

    chk_oc_source: assert property (
        (|oc_evt) |=> interrupt_status_main[PHES_F_OC]
        && ((overcurrent_source_phase & $past(oc_evt)) == $past(oc_evt)))
        else $error("overcurrent source or flag missing");

    chk_ov_source: assert property (
        (|ov_evt) |=> interrupt_status_main[PHES_F_OV]
        && ((overvoltage_source_phase & $past(ov_evt)) == $past(ov_evt)))
        else $error("overvoltage source or flag missing");

    chk_sag_source: assert property (
        (|sag_evt) |=> interrupt_status_main[PHES_F_SAG]
        && ((sag_source_phase & $past(sag_evt)) == $past(sag_evt)))
        else $error("sag source or flag missing");

    chk_tnl_track: assert property (
        ##1 total_power_noload_phase == $past(tnl_in))
        else $error("total no-load bits lag");

    chk_tnl_flag: assert property (
        $rose(|total_power_noload_phase) |-> interrupt_status_main[PHES_F_TNL])
        else $error("total no-load flag not set");

    chk_fnl_track: assert property (
        ##1 fundamental_noload_phase == $past(fnl_in))
        else $error("fundamental no-load bits lag");

    chk_fnl_flag: assert property (
        fnl_enter |=> interrupt_status_main[PHES_F_FNL])
        else $error("fundamental no-load flag not set");

    chk_anl_track: assert property (
        ##1 apparent_noload_phase == $past(anl_in))
        else $error("apparent no-load bits lag");

    chk_anl_flag: assert property (
        anl_enter |=> interrupt_status_main[PHES_F_ANL])
        else $error("apparent no-load flag not set");

    chk_irq_gate: assert property (
        irq == |(interrupt_status_main & interrupt_mask_main))
        else $error("irq disagrees with status and mask");

    chk_irq_noload: assert property (
        (tnl_enter && interrupt_mask_main[PHES_F_TNL] && !wr_imk) |=> irq)
        else $error("no-load interrupt missing");

    chk_ro_hold: assert property (
        (rif.wr_en && wr_src && !(|oc_evt) && !clr_vec[PHES_F_OC])
        |=> $stable(overcurrent_source_phase))
        else $error("write changed read-only source bits");

    // clearing a flag with no new event empties its phase bits too
    chk_oc_clear: assert property (
        (wr_ist && clr_vec[PHES_F_OC] && !(|oc_evt))
        |=> overcurrent_source_phase == 3'h0 && !interrupt_status_main[PHES_F_OC])
        else $error("overcurrent source not cleared");

    chk_ov_clear: assert property (
        (wr_ist && clr_vec[PHES_F_OV] && !(|ov_evt))
        |=> overvoltage_source_phase == 3'h0 && !interrupt_status_main[PHES_F_OV])
        else $error("overvoltage source not cleared");

    chk_sag_clear: assert property (
        (wr_ist && clr_vec[PHES_F_SAG] && !(|sag_evt))
        |=> sag_source_phase == 3'h0 && !interrupt_status_main[PHES_F_SAG])
        else $error("sag source not cleared");

    // a summary flag moves only on a phase entry or a clear
    chk_tnl_hold: assert property (
        (!tnl_enter && !clr_vec[PHES_F_TNL]) |=> $stable(interrupt_status_main[PHES_F_TNL]))
        else $error("total no-load flag moved");

    // bus channels reopen right after each answer is taken
    chk_wr_reopen: assert property (
        (bvalid && bready) |=> !bvalid && awready && wready)
        else $error("write channels not reopened");

    chk_rd_reopen: assert property (
        (rvalid && rready) |=> !rvalid && arready)
        else $error("read channel not reopened");

    cov_oc_irq: cover property (
        (|oc_evt) && interrupt_mask_main[PHES_F_OC] ##1 irq);
    cov_clr_race: cover property (wr_ist && clr_vec[PHES_F_OV] && (|ov_evt));
    cov_noload_in: cover property ($rose(|total_power_noload_phase));
    cov_read_src: cover property (rif.rd_en && rd_src && (|src_word));

endmodule // phes_regs
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import phes_pkg::*;

    // clock, reset and bus side of the block
    logic aclk, aresetn;
    logic [15:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    // detector side, one bit per phase
    logic [2:0] oc_evt, ov_evt, sag_evt, tnl_in, fnl_in, anl_in;
    logic irq;
    int n_fail;
    int n_tests;
    // event field lsb and summary flag per kind: overcurrent, overvoltage, sag
    int src_lsb[3] = '{3, 9, 12};
    int flag_pos[3] = '{17, 18, 16};

    phes_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .oc_evt(oc_evt), .ov_evt(ov_evt),
        .sag_evt(sag_evt), .tnl_in(tnl_in), .fnl_in(fnl_in), .anl_in(anl_in), .irq(irq));

    // 40 mhz clock
    always #12.5 aclk = ~aclk;

    // verdict, the single exit of the run
    task automatic final_report;
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // axi4-lite write, both channels offered together, released as taken
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        logic done;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        done = 1'b0;
        r = 2'h3;
        // one edge between transfers, so no signal is driven twice in a step
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (aw_ok && w_ok && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!done) begin
            chk("write answer", 32'h1, 32'h0);
        end
    endtask

    // axi4-lite read, rready held until the answer is sampled
    task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic took;
        logic done;
        int n;
        took = 1'b0;
        done = 1'b0;
        d = 32'hdead_beef;
        r = 2'h3;
        // one edge between transfers, so rready is never driven twice in a step
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (took && rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
            if (!took && arready) begin
                took = 1'b1;
                arvalid <= 1'b0;
            end
        end
        if (!done) begin
            chk("read answer", 32'h1, 32'h0);
        end
    endtask

    // write expecting okay
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, 4'hf, r);
        chk("bresp", {30'h0, PHES_OKAY}, {30'h0, r});
    endtask

    // read expecting okay and a given word
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk("rresp", {30'h0, PHES_OKAY}, {30'h0, r});
        chk(what, exp, d);
    endtask

    // sync reset for three edges
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // every register and the interrupt come up cleared
    task automatic reset_check;
        chk("irq reset", 32'h0, {31'h0, irq});
        rd_chk("src reset", PHES_A_SRC, 32'h0);
        rd_chk("noload reset", PHES_A_NL, 32'h0);
        rd_chk("status reset", PHES_A_IST, 32'h0);
        rd_chk("mask reset", PHES_A_IMK, 32'h0);
    endtask

    // no-load level inputs by kind: total, fundamental, apparent
    task automatic set_nl(input int k, input logic [2:0] v);
        case (k)
            0: tnl_in <= v;
            1: fnl_in <= v;
            default: anl_in <= v;
        endcase
    endtask

    // one phase event; phase a runs masked off so irq must stay low
    task automatic event_case(input int k, input int p);
        logic [2:0] hit;
        logic [31:0] flag;
        logic [31:0] irq_exp;
        hit = 3'h1 << p;
        flag = 32'h1 << flag_pos[k];
        irq_exp = (p == 0) ? 32'h0 : 32'h1;
        wr(PHES_A_IMK, (p == 0) ? 32'h0 : flag);
        case (k)
            0: oc_evt <= hit;
            1: ov_evt <= hit;
            default: sag_evt <= hit;
        endcase
        @(posedge aclk);
        oc_evt <= 3'h0;
        ov_evt <= 3'h0;
        sag_evt <= 3'h0;
        rd_chk("src phase", PHES_A_SRC, 32'h1 << (src_lsb[k] + p));
        rd_chk("summary", PHES_A_IST, flag);
        chk("irq masked", irq_exp, {31'h0, irq});
        // clearing the summary flag takes the phase bits with it
        wr(PHES_A_IST, flag);
        rd_chk("src cleared", PHES_A_SRC, 32'h0);
        rd_chk("summary cleared", PHES_A_IST, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask

    // one phase entering and leaving no-load
    task automatic nl_case(input int k, input int p);
        wr(PHES_A_IMK, 32'h1 << k);
        set_nl(k, 3'h1 << p);
        rd_chk("noload in", PHES_A_NL, 32'h1 << (3 * k + p));
        rd_chk("noload flag", PHES_A_IST, 32'h1 << k);
        chk("irq noload", 32'h1, {31'h0, irq});
        set_nl(k, 3'h0);
        rd_chk("noload out", PHES_A_NL, 32'h0);
        // summary stays until written off
        rd_chk("flag sticky", PHES_A_IST, 32'h1 << k);
        wr(PHES_A_IST, 32'h1 << k);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask

    // everything at once: reserved gaps, read-only writes, unmapped place
    task automatic all_case;
        logic [31:0] d;
        logic [1:0] r;
        wr(PHES_A_IMK, 32'hffff_ffff);
        rd_chk("mask impl", PHES_A_IMK, 32'h0007_0007);
        // only byte lane 2 written: the upper three flags drop, the rest stay
        axi_write(PHES_A_IMK, 32'h0, 4'h4, r);
        chk("mask lane bresp", {30'h0, PHES_OKAY}, {30'h0, r});
        rd_chk("mask lanes", PHES_A_IMK, 32'h0000_0007);
        oc_evt <= 3'h7;
        ov_evt <= 3'h7;
        sag_evt <= 3'h7;
        tnl_in <= 3'h7;
        fnl_in <= 3'h7;
        anl_in <= 3'h7;
        @(posedge aclk);
        oc_evt <= 3'h0;
        ov_evt <= 3'h0;
        sag_evt <= 3'h0;
        rd_chk("src all", PHES_A_SRC, 32'h0000_7e38);
        rd_chk("noload all", PHES_A_NL, 32'h0000_01ff);
        rd_chk("status all", PHES_A_IST, 32'h0007_0007);
        chk("irq all", 32'h1, {31'h0, irq});
        wr(PHES_A_SRC, 32'h0000_0000);
        wr(PHES_A_NL, 32'hffff_ffff);
        rd_chk("src kept", PHES_A_SRC, 32'h0000_7e38);
        rd_chk("noload kept", PHES_A_NL, 32'h0000_01ff);
        axi_read(16'he700, d, r);
        chk("unmapped rresp", {30'h0, PHES_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        axi_write(16'he700, 32'hffff_ffff, 4'hf, r);
        chk("unmapped bresp", {30'h0, PHES_SLVERR}, {30'h0, r});
        tnl_in <= 3'h0;
        fnl_in <= 3'h0;
        anl_in <= 3'h0;
        wr(PHES_A_IST, 32'hffff_ffff);
        wr(PHES_A_IMK, 32'h0);
        rd_chk("src none", PHES_A_SRC, 32'h0);
        rd_chk("status none", PHES_A_IST, 32'h0);
        // detector still firing while its flag is cleared: the set wins
        ov_evt <= 3'h2;
        wr(PHES_A_IST, 32'h0004_0000);
        ov_evt <= 3'h0;
        rd_chk("race src", PHES_A_SRC, 32'h0000_0400);
        rd_chk("race flag", PHES_A_IST, 32'h0004_0000);
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        final_report;
    end

    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {oc_evt, ov_evt, sag_evt, tnl_in, fnl_in, anl_in} = '0;
        n_fail = 0;
        n_tests = 0;
        do_reset;
        reset_check;
        for (int k = 0; k < 3; k++) begin
            for (int p = 0; p < 3; p++) begin
                event_case(k, p);
                nl_case(k, p);
            end
        end
        all_case;
        // a second reset in mid-run wipes a pending event
        oc_evt <= 3'h4;
        @(posedge aclk);
        oc_evt <= 3'h0;
        do_reset;
        reset_check;
        final_report;
    end
endmodule // tb
`default_nettype wire
